/* rtl/gpc_pkg.sv */
/*
  Package of the pin-change GPIO port block: register offsets, field
  positions, reset values and sizes shared by design and bench.
  Assumes an 8-bit register port with one-cycle strobes and 200 MHz clk.
*/
`default_nettype none

package gpc_pkg;

  localparam int NUM_PORTS = 4;
  localparam int PORT_WIDTH = 8;

  // port registers: base + 3 * port index
  localparam logic [7:0] PORT_INPUT_BASE = 8'h20;
  localparam logic [7:0] PORT_DIRECTION_BASE = 8'h21;
  localparam logic [7:0] PORT_OUTPUT_BASE = 8'h22;
  localparam logic [7:0] PORT_STRIDE = 8'h03;

  localparam logic [7:0] PIN_CHANGE_FLAG_OFFSET = 8'h3B;
  localparam logic [7:0] MCU_CONTROL_OFFSET = 8'h55;
  localparam logic [7:0] PIN_CHANGE_CONTROL_OFFSET = 8'h68;
  localparam logic [7:0] PIN_CHANGE_MASK_GROUP0_OFFSET = 8'h6B;
  localparam logic [7:0] PIN_CHANGE_MASK_GROUP1_OFFSET = 8'h6C;
  localparam logic [7:0] PIN_CHANGE_MASK_GROUP2_OFFSET = 8'h6D;
  localparam logic [7:0] PIN_CHANGE_MASK_GROUP3_OFFSET = 8'h73;

  localparam int GLOBAL_PULLUP_DISABLE_BIT = 4;

  localparam logic [7:0] PORT_REG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic PULLUP_DISABLE_RESET = 1'b0;

endpackage

`default_nettype wire

/* rtl/gpc_port.sv */
/*
  General-purpose I/O port logic for four eight-bit ports with the
  pin-change interrupt unit watching all 32 pins in four groups.
  Assumes an 8-bit register port on clk, read data one cycle after the
  read strobe, and asynchronous pin levels on pin_in.
*/
// Design decision made here: the address-and-strobe port.
`default_nettype none

module gpc_port
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // single-bit access: set or clear bit reg_bit of reg_addr; on flag and input regs set writes a one (clear/toggle), clear writes nothing
  input  wire logic        bit_set,
  input  wire logic        bit_clear,
  input  wire logic [2:0]  reg_bit,
  // cpu interrupt side
  input  wire logic        global_irq_enable,
  input  wire logic [3:0]  irq_ack,
  output logic [3:0]       irq_vector_request,
  output logic             irq,
  // pins
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  output logic      [31:0] pin_pullup
);

  localparam int NP = gpc_pkg::NUM_PORTS;
  localparam int PW = gpc_pkg::PORT_WIDTH;

  logic [31:0] port_output_reg;
  logic [31:0] port_direction_reg;
  logic [31:0] sync_stage1;
  logic [31:0] port_input_reg;
  logic [31:0] prev_sample;
  logic [31:0] pin_change_mask;
  logic [3:0]  pin_change_flag_reg;
  logic [3:0]  pin_change_control_reg;
  logic        global_pullup_disable;

  // any write, whole-byte or single-bit
  wire        any_write = reg_write | bit_set | bit_clear;
  wire [7:0]  bit_onehot = 8'h01 << reg_bit;

  // register selects
  wire sel_flag = reg_addr == gpc_pkg::PIN_CHANGE_FLAG_OFFSET;
  wire sel_ctrl = reg_addr == gpc_pkg::PIN_CHANGE_CONTROL_OFFSET;
  wire sel_mcu  = reg_addr == gpc_pkg::MCU_CONTROL_OFFSET;
  wire [3:0] sel_mask;
  assign sel_mask[0] = reg_addr == gpc_pkg::PIN_CHANGE_MASK_GROUP0_OFFSET;
  assign sel_mask[1] = reg_addr == gpc_pkg::PIN_CHANGE_MASK_GROUP1_OFFSET;
  assign sel_mask[2] = reg_addr == gpc_pkg::PIN_CHANGE_MASK_GROUP2_OFFSET;
  assign sel_mask[3] = reg_addr == gpc_pkg::PIN_CHANGE_MASK_GROUP3_OFFSET;

  wire [3:0] sel_in;
  wire [3:0] sel_dir;
  wire [3:0] sel_out;

  // current value of the addressed storage, for read and bit access
  logic [7:0] cur_value;
  logic [7:0] next_rdata;

  // value a bit access writes: read-modify-write except on toggle/clear regs
  wire        w1_reg = sel_flag | (|sel_in);
  wire [7:0]  eff_wdata = reg_write ? reg_wdata :
                          bit_set ? (w1_reg ? bit_onehot : (cur_value | bit_onehot)) :
                          (w1_reg ? 8'h00 : (cur_value & ~bit_onehot));

  // group change requests
  wire [31:0] pin_changed = port_input_reg ^ prev_sample;
  wire [3:0]  group_request;
  wire [3:0]  flag_clear = (sel_flag && any_write) ? eff_wdata[3:0] : 4'h0;

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_port
      assign sel_in[g]  = reg_addr == gpc_pkg::PORT_INPUT_BASE
                          + 8'(g) * gpc_pkg::PORT_STRIDE;
      assign sel_dir[g] = reg_addr == gpc_pkg::PORT_DIRECTION_BASE
                          + 8'(g) * gpc_pkg::PORT_STRIDE;
      assign sel_out[g] = reg_addr == gpc_pkg::PORT_OUTPUT_BASE
                          + 8'(g) * gpc_pkg::PORT_STRIDE;
      // masked-in pins with group enabled raise the request
      assign group_request[g] = pin_change_control_reg[g]
        & (|(pin_changed[g*PW +: PW] & pin_change_mask[g*PW +: PW]));

      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          port_output_reg[g*PW +: PW] <= gpc_pkg::PORT_REG_RESET;
          port_direction_reg[g*PW +: PW] <= gpc_pkg::PORT_REG_RESET;
          pin_change_mask[g*PW +: PW] <= gpc_pkg::MASK_RESET;
        end
        else if (any_write)
        begin
          if (sel_out[g])
            port_output_reg[g*PW +: PW] <= eff_wdata;
          else if (sel_in[g])
            port_output_reg[g*PW +: PW] <= port_output_reg[g*PW +: PW] ^ eff_wdata;
          if (sel_dir[g])
            port_direction_reg[g*PW +: PW] <= eff_wdata;
          if (sel_mask[g])
            pin_change_mask[g*PW +: PW] <= eff_wdata;
        end
      end
    end
  endgenerate

  // per-pin drive: each pin decided alone
  genvar p;
  generate
    for (p = 0; p < 32; p++)
    begin : g_pin
      assign pin_oe[p] = port_direction_reg[p] & ~reset;
      assign pin_out[p] = port_output_reg[p] & port_direction_reg[p] & ~reset;
      assign pin_pullup[p] = ~port_direction_reg[p] & port_output_reg[p]
                             & ~global_pullup_disable & ~reset;
    end
  endgenerate

  // read mux
  always_comb
  begin
    cur_value = 8'h00;
    for (int i = 0; i < NP; i++)
    begin
      if (sel_in[i])
        cur_value = port_input_reg[i*PW +: PW];
      if (sel_dir[i])
        cur_value = port_direction_reg[i*PW +: PW];
      if (sel_out[i])
        cur_value = port_output_reg[i*PW +: PW];
      if (sel_mask[i])
        cur_value = pin_change_mask[i*PW +: PW];
    end
    if (sel_flag)
      cur_value = {4'h0, pin_change_flag_reg};
    if (sel_ctrl)
      cur_value = {4'h0, pin_change_control_reg};
    if (sel_mcu)
      cur_value = 8'(global_pullup_disable) << gpc_pkg::GLOBAL_PULLUP_DISABLE_BIT;
  end

  assign next_rdata = reg_read ? cur_value : 8'h00;

  // synchronizer, previous sample and control state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync_stage1 <= '0;
      port_input_reg <= '0;
      prev_sample <= '0;
      reg_rdata <= 8'h00;
      pin_change_flag_reg <= gpc_pkg::FLAG_RESET;
      pin_change_control_reg <= gpc_pkg::CONTROL_RESET;
      global_pullup_disable <= gpc_pkg::PULLUP_DISABLE_RESET;
    end
    else
    begin
      sync_stage1 <= pin_in;
      port_input_reg <= sync_stage1;
      prev_sample <= port_input_reg;
      reg_rdata <= next_rdata;
      // set wins over software or acknowledge clear
      pin_change_flag_reg <= group_request
                             | (pin_change_flag_reg & ~flag_clear & ~irq_ack);
      if (sel_ctrl && any_write)
        pin_change_control_reg <= eff_wdata[3:0];
      if (sel_mcu && any_write)
        global_pullup_disable <= eff_wdata[gpc_pkg::GLOBAL_PULLUP_DISABLE_BIT];
    end
  end

  assign irq_vector_request = pin_change_flag_reg & pin_change_control_reg
                              & {4{global_irq_enable}};
  assign irq = |(pin_change_flag_reg & pin_change_control_reg);

endmodule

`default_nettype wire

/* dv/gpc_port_chk.sv */
/* Checker of the pin-change GPIO port.
   Assumes it is bound to gpc_port and sees only its ports. */
`default_nettype none
module gpc_port_chk (
  // clock, reset and register strobes
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        reg_write,
  input wire logic        bit_set,
  input wire logic        bit_clear,
  // interrupt side
  input wire logic        global_irq_enable,
  input wire logic [3:0]  irq_ack,
  input wire logic [3:0]  irq_vector_request,
  input wire logic        irq,
  // pins
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pullup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence pins_quiet; $stable(pin_in) [*6]; endsequence
  sequence ack_grp0; irq_ack == 4'h1 && irq_vector_request[0]; endsequence
  rst_tri_a: assert property (disable iff (1'b0)
    reset |-> (pin_oe | pin_out | pin_pullup) == 32'h0) else $error("pins active in reset");
  drv_only_a: assert property ((pin_out & ~pin_oe) == 32'h0) else $error("undriven value");
  pull_in_a: assert property ((pin_pullup & pin_oe) == 32'h0) else $error("pull-up on output");
  vec_gie_a: assert property (|irq_vector_request |-> global_irq_enable) else $error("vector");
  vec_irq_a: assert property (|irq_vector_request |-> irq) else $error("vector without irq");
  ack_clr_a: assert property (pins_quiet ##0 ack_grp0 |=> !irq_vector_request[0])
    else $error("ack did not clear");
  oe_cause_a: assert property ($changed(pin_oe) |-> $past(reg_write | bit_set | bit_clear))
    else $error("direction changed alone");
  quiet_rst_a: assert property ($fell(reset) |-> !irq [*6]) else $error("irq after reset");
endmodule
bind gpc_port gpc_port_chk u_chk (.clk, .reset, .reg_write, .bit_set, .bit_clear,
  .global_irq_enable, .irq_ack, .irq_vector_request, .irq, .pin_in, .pin_out, .pin_oe,
  .pin_pullup);
`default_nettype wire

/* dv/gpc_pins_model.sv */
/* Board model at the pins: external drivers, pull-ups and floating lines.
   Assumes enables and values come from the bench. */
`default_nettype none
module gpc_pins_model (
  input wire logic        clk,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pullup,
  input wire logic [31:0] ext_drv,
  input wire logic [31:0] ext_en,
  output logic     [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // floating lines without pull-up wander every cycle
  logic [31:0] flt = 32'h0;
  always @(posedge clk) flt <= ~flt;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
                | (~pin_oe & ~ext_en & (pin_pullup | flt));
endmodule
`default_nettype wire

/* dv/tb_gpc_port.sv */
/* Bench of the pin-change GPIO port.
   Assumes gpc_pkg, gpc_port, gpc_pins_model and the bound checker. */
`default_nettype none
module tb_gpc_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = gpc_pkg::PIN_CHANGE_CONTROL_OFFSET;
  localparam logic [7:0] FLG = gpc_pkg::PIN_CHANGE_FLAG_OFFSET;
  logic        clk = 0, reset = 1, reg_write = 0, reg_read = 0, bit_set = 0, bit_clear = 0;
  logic        global_irq_enable = 1, irq;
  logic [2:0]  reg_bit = 3'h0;
  logic [3:0]  irq_ack = 4'h0, irq_vector_request;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [31:0] pin_in, pin_out, pin_oe, pin_pullup, ext_drv = 32'h0, ext_en = 32'hFFFFFAFF;
  logic [7:0]  ma [4] = '{gpc_pkg::PIN_CHANGE_MASK_GROUP0_OFFSET,
    gpc_pkg::PIN_CHANGE_MASK_GROUP1_OFFSET, gpc_pkg::PIN_CHANGE_MASK_GROUP2_OFFSET,
    gpc_pkg::PIN_CHANGE_MASK_GROUP3_OFFSET};
  int          fail_count = 0, compares = 0, cyc = 0;
  always #2.5 clk = ~clk;
  gpc_port dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .bit_set, .bit_clear, .reg_bit, .global_irq_enable, .irq_ack, .irq_vector_request,
    .irq, .pin_in, .pin_out, .pin_oe, .pin_pullup);
  gpc_pins_model pins (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_drv, .ext_en, .pin_in);
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_read <= 1'b0;
    #1 ck(32'(reg_rdata), 32'(e));
  endtask
  task automatic bop(input logic s, input logic [7:0] a, input logic [2:0] b);
    @(posedge clk) {bit_set, bit_clear, reg_addr, reg_bit} <= {s, !s, a, b};
    @(posedge clk) {bit_set, bit_clear} <= 2'b00;
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    wr(8'h10, 8'hFF);
    foreach (ma[i]) rd(ma[i], 8'h00);
    rd(CTL, 8'h00);
    rd(FLG, 8'h00);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_port;
    wr(8'h24, 8'hF0);
    wr(8'h25, 8'hA5);
    ck({pin_oe[15:8], pin_out[15:8], pin_pullup[15:8]}, 32'hF0A005);
    idle(2);
    rd(8'h23, 8'hA5);
    wr(8'h23, 8'h0F);
    ck(pin_pullup, 32'h00000A00);
    rd(8'h25, 8'hAA);
    wr(gpc_pkg::MCU_CONTROL_OFFSET, 8'h10);
    ck(pin_pullup, 32'h0);
    bop(1'b1, 8'h24, 3'h0);
    bop(1'b0, 8'h24, 3'h7);
    ck({pin_oe[15:8], pin_out[15:8]}, 32'h7120);
  endtask
  task automatic t_irq;
    ext_en <= 32'hFFFFFFFF;
    wr(CTL, 8'h01);
    ext_drv[0] <= 1'b1;
    idle(8);
    ck(32'(irq), 32'h0);
    for (int g = 0; g < 4; g++)
    begin
      wr(CTL, 8'(1 << g));
      wr(ma[g], 8'h02);
      ext_drv[8 * g + 1] <= 1'b1;
      idle(6);
      ck(32'(irq_vector_request), 32'(1 << g));
      rd(FLG, 8'(1 << g));
      wr(FLG, 8'(1 << g));
      ck(32'(irq_vector_request), 32'h0);
      wr(ma[g], 8'h00);
    end
    wr(ma[0], 8'h02);
    wr(CTL, 8'h01);
    ext_drv[1] <= 1'b0;
    idle(8);
    @(posedge clk) global_irq_enable <= 1'b0;
    #1 ck({irq_vector_request, irq}, 32'h01);
    wr(CTL, 8'h00);
    ck(32'(irq), 32'h0);
    wr(CTL, 8'h01);
    wr(FLG, 8'h00);
    ck(32'(irq), 32'h1);
    @(posedge clk) {global_irq_enable, irq_ack} <= 5'h11;
    @(posedge clk) irq_ack <= 4'h0;
    #1 ck({irq_vector_request, irq}, 32'h0);
  endtask
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      stop_test;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_port;
    t_irq;
    stop_test;
  end
endmodule
`default_nettype wire
